// ==== logic/ascp_cfg.svh ====
// Constants of the serial configuration port: map, field positions, frame counts
// Summary of operation
// - Fourteen address bits, MSB first, pick register
// - Eight data bits sampled, stored in addressed register
// - Flag one enters readback, blocks writes until zero
// - Read frame shifts register out MSB first
// - Serial output changes after falling serial clock
// - Serial output high impedance outside readback mode
// - Soft reset bit restores defaults, self-clears
// - Dither off needs field 11 and aux bits
// - Lane-order bit picks two-lane bit mapping
// - Lane swap exchanges lanes, two-lane only
// - Lane-count bit picks two lanes or one
// - Pattern enable replaces samples with test pattern
// - Overrange-in-bit0 puts overrange flag on bit 0
// - Alignment bit aligns both channel patterns
// - Coding bit: two's complement or offset binary
// - One input bit per rising clock, select low
// - Commit every 24th edge, drop partial frames
`ifndef ASCP_CFG_SVH
`define ASCP_CFG_SVH

// Register map, index 0 in the low slice
`define ASCP_NREG 25
`define ASCP_ADDR_TAB {14'h70a, 14'h608, 14'h539, 14'h534, 14'h522, 14'h51d, 14'h439, 14'h434, \
    14'h422, 14'h41d, 14'h027, 14'h025, 14'h015, 14'h013, 14'h00f, 14'h00e, 14'h00b, 14'h00a, \
    14'h009, 14'h007, 14'h006, 14'h005, 14'h004, 14'h003, 14'h001}
// Storable bits per register; reserved bits read zero
`define ASCP_MASK_TAB {8'h81, 8'hc0, 8'h08, 8'h28, 8'h02, 8'h02, 8'h08, 8'h28, 8'h02, 8'h02, \
    8'hc0, 8'hff, 8'h6d, 8'h03, 8'hfc, 8'hff, 8'hf0, 8'h0f, 8'h03, 8'h01, 8'h02, 8'h01, 8'h01, \
    8'h01, 8'h3c}
`define ASCP_REG_RST 8'h00

// Indices of registers that steer logic
`define ASCP_IX_DITH 0
`define ASCP_IX_ORDER 1
`define ASCP_IX_SWAP 2
`define ASCP_IX_LANES 3
`define ASCP_IX_PATRST 4
`define ASCP_IX_OVR 5
`define ASCP_IX_FMT 6
`define ASCP_IX_PATA 7
`define ASCP_IX_PATB 8
`define ASCP_IX_UPH 9
`define ASCP_IX_UPL 10
`define ASCP_IX_AUXA 17
`define ASCP_IX_SPA 18
`define ASCP_IX_AUXB 21
`define ASCP_IX_SPB 22

// Field positions
`define ASCP_B_SOFT_RST 0
`define ASCP_B_PAT_EN 1
`define ASCP_B_ALIGN 1
`define ASCP_B_CODING 0
`define ASCP_B_AUX_HI 5
`define ASCP_B_AUX_LO 3
`define ASCP_B_SPECIAL 3

// Frame geometry
`define ASCP_FRAME_LAST 5'd23
`define ASCP_ADDR_LAST 5'd15

`endif

// ==== logic/ascp_pkg.sv ====
// Types of the serial configuration port
`default_nettype none
package ascp_pkg;

    // Frame phase
    typedef enum logic [1:0] {
        ASCP_IDLE = 2'b00,
        ASCP_ADDR = 2'b01,
        ASCP_DATA = 2'b10
    } ascp_fsm_t;

    // Decoded settings for the datapath
    typedef struct packed {
        logic dither_off_first_channel;
        logic dither_off_second_channel;
        logic lane_count_select;
        logic lane_order;
        logic lane_swap;
        logic pattern_en;
        logic [3:0] pattern_first;
        logic [3:0] pattern_second;
        logic [13:0] user_pattern;
        logic pattern_align;
        logic offset_binary;
        logic overrange_in_bit0;
        logic special_mode_first_channel;
        logic special_mode_second_channel;
    } ascp_cfg_t;

    // Whole state of the port
    typedef struct packed {
        ascp_fsm_t fsm;
        logic sclk_q;
        logic [4:0] cnt;
        logic [22:0] sh;
        logic rd_mode;
        logic [7:0] txsh;
        logic sout;
        logic oe_n;
        ascp_cfg_t cfg;
        logic [1:0][13:0] smp;
        logic [24:0][7:0] regs;
    } ascp_state_t;

endpackage
`default_nettype wire

// ==== logic/ascp_top.sv ====
// Serial configuration port, register bank and output formatting
`timescale 1ns/1ns
`default_nettype none
`include "ascp_cfg.svh"

module ascp_top (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic serial_select_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_in_line_i,
    input wire logic [1:0][13:0] sample_i,
    input wire logic [1:0] overrange_flag_i,
    input wire logic [1:0][13:0] pattern_data_i,
    output logic serial_out_line_o,
    output logic serial_out_oe_n_o,
    output ascp_pkg::ascp_cfg_t cfg_o,
    output logic [1:0][13:0] sample_o
);

    localparam logic [`ASCP_NREG*14-1:0] ADDR_TAB = `ASCP_ADDR_TAB;
    localparam logic [`ASCP_NREG*8-1:0] MASK_TAB = `ASCP_MASK_TAB;

    ascp_pkg::ascp_state_t q;
    ascp_pkg::ascp_state_t next_q;

    logic sclk_rise;
    logic sclk_fall;
    logic [13:0] rd_addr;
    logic [7:0] rd_val;
    logic [23:0] word;
    logic commit;
    logic wr_en;
    logic soft_rst;

    // Edge detection on the sampled serial clock
    assign sclk_rise = serial_clk_i & ~q.sclk_q;
    assign sclk_fall = ~serial_clk_i & q.sclk_q;

    // Address and word as seen on the current edge
    assign rd_addr = {q.sh[12:0], serial_in_line_i};
    assign word = {q.sh, serial_in_line_i};

    // Frame completes on 24th rising edge with select low
    assign commit = ~serial_select_n_i & sclk_rise & (q.cnt == `ASCP_FRAME_LAST);

    // Only frames whose flag is zero may store
    assign wr_en = commit & ~word[23];

    // Soft reset written to the pattern/reset register
    assign soft_rst = wr_en & (word[21:8] == ADDR_TAB[`ASCP_IX_PATRST*14 +: 14])
        & word[`ASCP_B_SOFT_RST];

    // Readback value of the addressed register
    always_comb begin
        rd_val = 8'h00;
        for (int i = 0; i < `ASCP_NREG; i++) begin
            if (ADDR_TAB[i*14 +: 14] == rd_addr) begin
                rd_val = q.regs[i];
            end
        end
    end

    // Next state of the whole port
    always_comb begin
        next_q = q;
        next_q.sclk_q = serial_clk_i;

        // Deselected: clock ignored, counting restarts
        if (serial_select_n_i) begin
            next_q.fsm = ascp_pkg::ASCP_IDLE;
            next_q.cnt = 5'h00;
        end else if (sclk_rise) begin
            // One input bit per rising edge
            next_q.sh = {q.sh[21:0], serial_in_line_i};

            // Leading flag sets or leaves readback mode
            if (q.cnt == 5'h00) begin
                next_q.rd_mode = serial_in_line_i;
            end

            // Address complete: fetch register for readback
            if (q.cnt == `ASCP_ADDR_LAST && q.rd_mode) begin
                next_q.txsh = rd_val;
            end

            // Bit counter and phase, back-to-back frames
            if (q.cnt == `ASCP_FRAME_LAST) begin
                next_q.cnt = 5'h00;
                next_q.fsm = ascp_pkg::ASCP_ADDR;
            end else begin
                next_q.cnt = q.cnt + 5'h01;
                if (q.cnt >= `ASCP_ADDR_LAST) begin
                    next_q.fsm = ascp_pkg::ASCP_DATA;
                end else begin
                    next_q.fsm = ascp_pkg::ASCP_ADDR;
                end
            end
        end else if (sclk_fall && q.fsm == ascp_pkg::ASCP_DATA && q.rd_mode) begin
            // Read data moves on after falling edge, MSB first
            next_q.sout = q.txsh[7];
            next_q.txsh = {q.txsh[6:0], 1'b0};
        end

        // Register store on a committed write frame
        if (soft_rst) begin
            for (int i = 0; i < `ASCP_NREG; i++) begin
                next_q.regs[i] = `ASCP_REG_RST;
            end
        end else if (wr_en) begin
            for (int i = 0; i < `ASCP_NREG; i++) begin
                if (ADDR_TAB[i*14 +: 14] == word[21:8]) begin
                    next_q.regs[i] = word[7:0] & MASK_TAB[i*8 +: 8];
                end
            end
        end

        // Output driven only in readback mode
        next_q.oe_n = ~next_q.rd_mode;

        // Decoded settings, taken from the stored bank
        next_q.cfg.dither_off_first_channel = (q.regs[`ASCP_IX_DITH][5:4] == 2'b11)
            & q.regs[`ASCP_IX_AUXA][`ASCP_B_AUX_HI] & q.regs[`ASCP_IX_AUXA][`ASCP_B_AUX_LO];
        next_q.cfg.dither_off_second_channel = (q.regs[`ASCP_IX_DITH][3:2] == 2'b11)
            & q.regs[`ASCP_IX_AUXB][`ASCP_B_AUX_HI] & q.regs[`ASCP_IX_AUXB][`ASCP_B_AUX_LO];
        next_q.cfg.lane_count_select = q.regs[`ASCP_IX_LANES][0];
        next_q.cfg.lane_order = q.regs[`ASCP_IX_ORDER][0] & ~q.regs[`ASCP_IX_LANES][0];
        next_q.cfg.lane_swap = q.regs[`ASCP_IX_SWAP][0] & ~q.regs[`ASCP_IX_LANES][0];
        next_q.cfg.pattern_en = q.regs[`ASCP_IX_PATRST][`ASCP_B_PAT_EN];
        next_q.cfg.pattern_first = q.regs[`ASCP_IX_PATA][3:0];
        next_q.cfg.pattern_second = q.regs[`ASCP_IX_PATB][7:4];
        next_q.cfg.user_pattern = {q.regs[`ASCP_IX_UPH], q.regs[`ASCP_IX_UPL][7:2]};
        next_q.cfg.pattern_align = q.regs[`ASCP_IX_FMT][`ASCP_B_ALIGN];
        next_q.cfg.offset_binary = q.regs[`ASCP_IX_FMT][`ASCP_B_CODING];
        next_q.cfg.overrange_in_bit0 = q.regs[`ASCP_IX_OVR][0];
        next_q.cfg.special_mode_first_channel = q.regs[`ASCP_IX_SPA][`ASCP_B_SPECIAL];
        next_q.cfg.special_mode_second_channel = q.regs[`ASCP_IX_SPB][`ASCP_B_SPECIAL];

        // Sample formatting per channel
        for (int c = 0; c < 2; c++) begin
            if (q.cfg.pattern_en) begin
                next_q.smp[c] = pattern_data_i[c];
            end else begin
                next_q.smp[c] = sample_i[c];
                if (q.cfg.offset_binary) begin
                    next_q.smp[c][13] = ~sample_i[c][13];
                end
                if (q.cfg.overrange_in_bit0) begin
                    next_q.smp[c][0] = overrange_flag_i[c];
                end
            end
        end
    end

    // State register, defaults on reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            q <= '0;
            q.oe_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from the state register
    assign serial_out_line_o = q.sout;
    assign serial_out_oe_n_o = q.oe_n;
    assign cfg_o = q.cfg;
    assign sample_o = q.smp;

    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence s_edge_in;
        !serial_select_n_i && sclk_rise;
    endsequence

    sequence s_last_edge;
        s_edge_in ##0 (q.cnt == `ASCP_FRAME_LAST);
    endsequence

    sequence s_read_fetch;
        s_edge_in ##0 (q.cnt == `ASCP_ADDR_LAST) ##0 q.rd_mode;
    endsequence

    sequence s_drive_edge;
        sclk_fall && !serial_select_n_i && q.fsm == ascp_pkg::ASCP_DATA && q.rd_mode;
    endsequence

    a_input_sample: assert property (
        s_edge_in |=> q.sh[0] == $past(serial_in_line_i))
        else $error("input bit not taken on rising edge");

    a_frame_wrap: assert property (
        s_last_edge |=> q.cnt == 5'h00 && q.fsm == ascp_pkg::ASCP_ADDR)
        else $error("frame count did not wrap at 24");

    a_deselect_restart: assert property (
        serial_select_n_i |=> q.cnt == 5'h00 && q.fsm == ascp_pkg::ASCP_IDLE)
        else $error("count not cleared while deselected");

    a_deselect_hold: assert property (
        serial_select_n_i ##1 serial_select_n_i |-> $stable(q.sh) && $stable(q.txsh))
        else $error("shifters moved while deselected");

    a_read_blocks: assert property (
        s_last_edge ##0 q.sh[22] && !soft_rst |=> $stable(q.regs))
        else $error("register written during readback frame");

    a_read_mode_set: assert property (
        s_edge_in ##0 (q.cnt == 5'h00) |=> q.rd_mode == $past(serial_in_line_i))
        else $error("readback mode not taken from flag");

    a_read_fetch: assert property (
        s_read_fetch |=> q.txsh == $past(rd_val))
        else $error("readback value not loaded after address");

    a_read_msb: assert property (
        s_drive_edge |=> q.txsh == {$past(q.txsh[6:0]), 1'b0})
        else $error("readback not shifted MSB first");

    a_out_falling: assert property (
        s_drive_edge |=> q.sout == $past(q.txsh[7]))
        else $error("output bit not presented after falling edge");

    a_out_steady: assert property (
        !sclk_fall |=> $stable(q.sout))
        else $error("output changed without falling edge");

    a_hiz_idle: assert property (
        !q.rd_mode |-> q.oe_n)
        else $error("output driven outside readback");

    a_write_store: assert property (
        wr_en && !soft_rst && word[21:8] == 14'h007 |=> q.regs[`ASCP_IX_OVR] == {7'h00, $past(word[0])})
        else $error("write data not stored");

    a_soft_reset: assert property (
        soft_rst |=> q.regs == '0 ##1 q.cfg.pattern_en == 1'b0)
        else $error("soft reset did not restore defaults");

    a_lane_swap: assert property (
        q.cfg.lane_swap |-> $past(q.regs[`ASCP_IX_SWAP][0]) && !q.cfg.lane_count_select)
        else $error("lane swap outside two-lane mode");

    a_dither_off: assert property (
        q.cfg.dither_off_first_channel |-> $past(q.regs[`ASCP_IX_DITH][5:4]) == 2'b11
            && $past(q.regs[`ASCP_IX_AUXA]) == 8'h28)
        else $error("dither off without both controls");

    a_pattern_out: assert property (
        q.cfg.pattern_en |=> sample_o == $past(pattern_data_i))
        else $error("pattern not substituted");

    a_coding: assert property (
        !q.cfg.pattern_en && !q.cfg.overrange_in_bit0 |=>
            sample_o[0][13] == ($past(sample_i[0][13]) ^ $past(q.cfg.offset_binary)))
        else $error("output coding wrong");

    a_ovr_bit0: assert property (
        !q.cfg.pattern_en && q.cfg.overrange_in_bit0 |=> sample_o[1][0] == $past(overrange_flag_i[1]))
        else $error("overrange not on bit 0");

    // Taken edges by frame position
    sequence s_flag_edge;
        s_edge_in ##0 (q.cnt == 5'h00);
    endsequence

    sequence s_mid_edge;
        s_edge_in ##0 (q.cnt != `ASCP_FRAME_LAST);
    endsequence

    // Counter steps once per taken bit
    a_count_step: assert property (
        s_mid_edge |=> q.cnt == $past(q.cnt) + 5'h01)
        else $error("bit count did not step");

    // Counter holds between serial edges
    a_count_hold: assert property (
        !serial_select_n_i && !sclk_rise |=> $stable(q.cnt))
        else $error("bit count moved without rising edge");

    // Older bits move up the shifter
    a_shift_chain: assert property (
        s_edge_in |=> q.sh[22:1] == $past(q.sh[21:0]))
        else $error("input shifter chain broken");

    // Bank changes only on a committed frame
    a_commit_only: assert property (
        !commit |=> $stable(q.regs))
        else $error("register changed outside a full frame");

    // Deselected port keeps bank and output
    a_deselect_quiet: assert property (
        serial_select_n_i |=> $stable(q.sout) && $stable(q.regs))
        else $error("port active while deselected");

    // Zero flag leaves readback and releases pin
    a_flag_clear: assert property (
        s_flag_edge ##0 !serial_in_line_i |=> !q.rd_mode && q.oe_n)
        else $error("readback not left on zero flag");

    // One flag drives the output pin
    a_flag_drive: assert property (
        s_flag_edge ##0 serial_in_line_i |=> !q.oe_n)
        else $error("output not driven in readback");

    // Readback mode moves only on the flag bit
    a_mode_hold: assert property (
        serial_select_n_i || !sclk_rise || q.cnt != 5'h00 |=> $stable(q.rd_mode))
        else $error("readback mode changed off the flag bit");

    // Reserved positions never hold a one
    a_reserved_zero: assert property (
        (q.regs & ~MASK_TAB) == '0)
        else $error("reserved bit stored");

    // Soft reset bit never stays set
    a_soft_self_clear: assert property (
        !q.regs[`ASCP_IX_PATRST][`ASCP_B_SOFT_RST])
        else $error("soft reset bit did not clear");

    // No output movement outside data phase
    a_drive_window: assert property (
        sclk_fall && q.fsm != ascp_pkg::ASCP_DATA |=> $stable(q.sout) && $stable(q.txsh))
        else $error("output moved outside data phase");

    // Readback shifter empty after last bit
    a_read_drain: assert property (
        s_drive_edge ##0 (q.cnt == `ASCP_FRAME_LAST) |=> q.txsh == 8'h00)
        else $error("readback shifter not drained");

    // Lane count follows its register bit
    a_lane_count: assert property (
        1'b1 |=> q.cfg.lane_count_select == $past(q.regs[`ASCP_IX_LANES][0]))
        else $error("lane count not decoded");

    // Lane order only in two-lane mode
    a_lane_order: assert property (
        q.cfg.lane_order |-> !q.cfg.lane_count_select && $past(q.regs[`ASCP_IX_ORDER][0]))
        else $error("lane order outside two-lane mode");

    // Pattern alignment follows its bit
    a_align_cfg: assert property (
        1'b1 |=> q.cfg.pattern_align == $past(q.regs[`ASCP_IX_FMT][`ASCP_B_ALIGN]))
        else $error("pattern alignment not decoded");

    // Coding follows its bit
    a_coding_cfg: assert property (
        1'b1 |=> q.cfg.offset_binary == $past(q.regs[`ASCP_IX_FMT][`ASCP_B_CODING]))
        else $error("output coding not decoded");

    // Pattern enable follows its bit
    a_pattern_cfg: assert property (
        1'b1 |=> q.cfg.pattern_en == $past(q.regs[`ASCP_IX_PATRST][`ASCP_B_PAT_EN]))
        else $error("pattern enable not decoded");

    // Second channel dither needs both controls
    a_dither_second: assert property (
        q.cfg.dither_off_second_channel |-> $past(q.regs[`ASCP_IX_DITH][3:2]) == 2'b11
            && $past(q.regs[`ASCP_IX_AUXB]) == 8'h28)
        else $error("second channel dither off without both controls");

    // Field other than 11 keeps dither on
    a_dither_field: assert property (
        q.regs[`ASCP_IX_DITH][5:4] != 2'b11 |=> !q.cfg.dither_off_first_channel)
        else $error("dither off with field not 11");

    // Plain samples pass unchanged
    a_sample_pass: assert property (
        !q.cfg.pattern_en && !q.cfg.offset_binary && !q.cfg.overrange_in_bit0 |=> sample_o == $past(sample_i))
        else $error("plain samples altered");

    // First channel overrange on bit 0
    a_ovr_first: assert property (
        !q.cfg.pattern_en && q.cfg.overrange_in_bit0 |=> sample_o[0][0] == $past(overrange_flag_i[0]))
        else $error("first channel overrange not on bit 0");

    // Second channel coding of the MSB
    a_coding_second: assert property (
        !q.cfg.pattern_en |=> sample_o[1][13] == ($past(sample_i[1][13]) ^ $past(q.cfg.offset_binary)))
        else $error("second channel coding wrong");

endmodule // ascp_top
`default_nettype wire

// ==== verif/ascp_ctrl_model.sv ====
// Serial controller model driving select, serial clock and serial data
`timescale 1ns/1ns
`default_nettype none

module ascp_ctrl_model (
    input wire logic clk_sys_i,
    input wire logic serial_out_wire_i,
    output logic serial_select_n_o,
    output logic serial_clk_o,
    output logic serial_in_line_o
);
    logic [7:0] rx;

    // Idle: deselected, clock parked low
    initial begin
        serial_select_n_o = 1'b1;
        serial_clk_o = 1'b0;
        serial_in_line_o = 1'b0;
        rx = 8'h00;
    end

    // One select window of n bits, MSB first; clock low 3 cycles, high 2
    task automatic send(input logic [47:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_select_n_o <= 1'b0;
            serial_clk_o <= 1'b0;
            serial_in_line_o <= v[i];
            repeat (3) @(posedge clk_sys_i);
            serial_clk_o <= 1'b1;
            rx = {rx[6:0], serial_out_wire_i};
            repeat (2) @(posedge clk_sys_i);
        end
        serial_clk_o <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        serial_select_n_o <= 1'b1;
        serial_in_line_o <= ~serial_in_line_o; // Released line shows no stale value
        repeat (3) @(posedge clk_sys_i);
    endtask
endmodule // ascp_ctrl_model
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench of the serial configuration port
`timescale 1ns/1ns
`default_nettype none
`include "ascp_cfg.svh"

module testbench;
    localparam logic [24:0][13:0] ADDRS = `ASCP_ADDR_TAB;
    localparam logic [24:0][7:0] MASKS = `ASCP_MASK_TAB;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1; // power-up delay counted as over at time zero
    logic sel_n, sclk, sdi, sout, oe_n;
    logic [1:0][13:0] smp_in = {14'h2a5a, 14'h1234};
    logic [1:0][13:0] pat_in = {14'h0f0f, 14'h3c3c};
    logic [1:0] overrange_flag = 2'b01;
    logic [1:0][13:0] smp_out;
    ascp_pkg::ascp_cfg_t cfg;
    wire logic sdo_wire;
    int fail_count = 0;
    int n_compared = 0;

    assign sdo_wire = oe_n ? 1'bz : sout;

    // 250 MHz clock
    always #2 clk_sys_i = ~clk_sys_i;

    ascp_top u_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .serial_select_n_i(sel_n), .serial_clk_i(sclk),
        .serial_in_line_i(sdi), .sample_i(smp_in), .overrange_flag_i(overrange_flag), .pattern_data_i(pat_in),
        .serial_out_line_o(sout), .serial_out_oe_n_o(oe_n), .cfg_o(cfg), .sample_o(smp_out)
    );

    ascp_ctrl_model u_ctrl (
        .clk_sys_i(clk_sys_i), .serial_out_wire_i(sdo_wire), .serial_select_n_o(sel_n),
        .serial_clk_o(sclk), .serial_in_line_o(sdi)
    );

    // Compare and count
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Register write frame: flag zero, fixed one, address, data
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        u_ctrl.send({24'h000000, 1'b0, 1'b1, a, d}, 24);
    endtask

    // Register read frame and compare of returned byte
    task automatic rd(input logic [13:0] a, input logic [7:0] exp);
        u_ctrl.send({24'h000000, 1'b1, 1'b1, a, 8'h00}, 24);
        check(u_ctrl.rx, exp);
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        fail_count++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (25) @(posedge clk_sys_i);
        for (int i = 0; i < 25; i++) rd(ADDRS[i], 8'h00);
        check(oe_n, 1'b0);
        $display("test reset values done");
        // Every storable bit set; lane-count one forces lane order and swap off
        for (int i = 0; i < 25; i++) wr(ADDRS[i], MASKS[i]);
        check(oe_n, 1'b1);
        for (int i = 0; i < 25; i++) rd(ADDRS[i], MASKS[i]);
        rd(14'h00e, 8'hff);
        check(cfg, {1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'hf, 4'hf, 14'h3fff, 5'h1f});
        check(smp_out, pat_in);
        $display("test full write done");
        // Two lanes, pattern off, aux dither bits cleared on first channel
        wr(14'h005, 8'h00);
        wr(14'h006, 8'h00);
        wr(14'h434, 8'h00);
        check({cfg.lane_order, cfg.lane_swap}, 2'b11);
        check({cfg.dither_off_first_channel, cfg.dither_off_second_channel}, 2'b01);
        check(smp_out, {14'h0a5a, 14'h3235});
        $display("test output format done");
        // Back-to-back frames, then a trailing partial frame
        u_ctrl.send({1'b0, 1'b1, 14'h00e, 8'h5a, 1'b0, 1'b1, 14'h025, 8'ha5}, 48);
        rd(14'h025, 8'ha5);
        u_ctrl.send({12'h000, 1'b0, 1'b1, 14'h00e, 8'h3c, 12'h400}, 36);
        wr(14'h025, 8'h11);
        rd(14'h00e, 8'h3c);
        rd(14'h025, 8'h11);
        $display("test framing done");
        // Soft reset restores defaults and clears itself
        wr(14'h006, 8'h01);
        for (int i = 0; i < 25; i++) rd(ADDRS[i], 8'h00);
        check(cfg, 40'h0);
        $display("test soft reset done");
        // Hardware reset in mid-run clears bank and readback mode
        wr(14'h025, 8'h77);
        rd(14'h025, 8'h77);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (25) @(posedge clk_sys_i);
        check({oe_n, cfg}, {1'b1, 33'h0});
        rd(14'h025, 8'h00);
        $display("test hardware reset done");
        close_out();
    end
endmodule // testbench
`default_nettype wire
